// >>> rtl/lcf_pkg.sv
// Shared constants and types for the load cell filter and compare block
package lcf_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH     = 4;
  localparam int SAMPLE_W   = 24;
  localparam int HIST_DEPTH = 8;
  localparam int SUM_W      = 27;

  // ---------------------------------------------------------------
  // Depth codes: code n means 2**n samples averaged
  // ---------------------------------------------------------------
  localparam logic [1:0] DEPTH_1   = 2'h0;
  localparam logic [1:0] DEPTH_2   = 2'h1;
  localparam logic [1:0] DEPTH_4   = 2'h2;
  localparam logic [1:0] DEPTH_8   = 2'h3;
  localparam logic [1:0] DEPTH_RST = DEPTH_1;

  // ---------------------------------------------------------------
  // Host command bytes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_GET_FILTER = 8'h01;
  localparam logic [7:0] CMD_SET_FILTER = 8'h02;
  localparam logic [7:0] CMD_GET_MODE   = 8'h03;
  localparam logic [7:0] CMD_SET_MODE   = 8'h04;
  localparam logic [7:0] CMD_GET_IO     = 8'h05;
  localparam logic [3:0] MODE_RST       = 4'h0;
  localparam logic [3:0] PIN_RST        = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FCH   = 3'b001,
    ST_SCH   = 3'b010,
    ST_SVAL  = 3'b011,
    ST_SMODE = 3'b100,
    ST_REPLY = 3'b101
  } lcf_state_e;

  typedef struct packed {
    logic [1:0]          chan;
    logic [SAMPLE_W-1:0] data;
  } lcf_sample_s;

  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } lcf_hbyte_s;

endpackage

// >>> rtl/lcf_avg.sv
// Moving-average filter for one channel, depth 1, 2, 4 or 8
`timescale 1ns/1ps
module lcf_avg (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Control
  input  wire logic                         clear,
  input  wire logic [1:0]                   depth,
  // Sample in
  input  wire logic                         in_valid,
  input  wire logic [lcf_pkg::SAMPLE_W-1:0] in_data,
  // Result out
  output logic                              out_valid,
  output logic [lcf_pkg::SAMPLE_W-1:0]      out_data,
  output logic                              full
);

  logic [lcf_pkg::SAMPLE_W-1:0] hist [lcf_pkg::HIST_DEPTH];
  logic [2:0]                   wp;
  logic [3:0]                   fill;
  logic [3:0]                   need;
  logic [lcf_pkg::SUM_W-1:0]    sum;
  logic [lcf_pkg::SAMPLE_W-1:0] prev;

  assign need = 4'h1 << depth;
  assign full = fill >= need;
  assign prev = hist[wp - 3'h1];

  // Sum of the new sample and the newest retained ones
  always_comb begin
    sum = lcf_pkg::SUM_W'(in_data);
    for (int k = 1; k < lcf_pkg::HIST_DEPTH; k++) begin
      if (4'(k) < need) begin
        sum = sum + lcf_pkg::SUM_W'(hist[wp - 3'(k)]);
      end
    end
  end

  // [RL1] newest overwrites oldest
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp   <= 3'h0;
      fill <= 4'h0;
      for (int i = 0; i < lcf_pkg::HIST_DEPTH; i++) hist[i] <= '0;
    end else if (clear) begin
      wp   <= 3'h0;
      fill <= 4'h0;
      for (int i = 0; i < lcf_pkg::HIST_DEPTH; i++) hist[i] <= '0;
    end else if (in_valid) begin
      hist[wp] <= in_data;
      wp       <= wp + 3'h1;
      if (fill != 4'h8) fill <= fill + 4'h1;
    end
  end

  // [RL2] [RL3] [RL4] [RL6] mean by power-of-two shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid && !clear;
      if (in_valid && !clear) begin
        out_data <= lcf_pkg::SAMPLE_W'(sum >> depth);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_pass;
    @(posedge clk) disable iff (rst)
    in_valid && !clear && depth == lcf_pkg::DEPTH_1
      |=> out_valid && out_data == $past(in_data);
  endproperty
  a_pass: assert property (p_pass) else $error("depth 1 not raw"); // RL3

  property p_avg2;
    @(posedge clk) disable iff (rst)
    in_valid && !clear && depth == lcf_pkg::DEPTH_2
      |=> out_data == lcf_pkg::SAMPLE_W'(
            ({1'b0, $past(in_data)} + {1'b0, $past(prev)}) >> 1);
  endproperty
  a_avg2: assert property (p_avg2) else $error("depth 2 mean wrong"); // RL4

  property p_full8;
    @(posedge clk) disable iff (rst)
    depth == lcf_pkg::DEPTH_8 && full |-> fill == 4'h8;
  endproperty
  a_full8: assert property (p_full8) else $error("depth 8 early full"); // RL6

  property p_clear;
    @(posedge clk) disable iff (rst)
    clear |=> fill == 4'h0 && !out_valid;
  endproperty
  a_clear: assert property (p_clear) else $error("clear kept history"); // RL22

  property p_result;
    @(posedge clk) disable iff (rst)
    out_valid |-> $past(in_valid);
  endproperty
  a_result: assert property (p_result) else $error("result w/o sample"); // RL2

  c_full8: cover property (@(posedge clk) depth == lcf_pkg::DEPTH_8 && full);

endmodule

// >>> rtl/lcf_host_port.sv
// Byte-wide input and output holding registers facing the host
`timescale 1ns/1ps
module lcf_host_port (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Host side
  input  wire logic               wr,
  input  wire lcf_pkg::lcf_hbyte_s wr_byte,
  input  wire logic               rd,
  output logic                    input_holding_full,
  output logic                    output_holding_full,
  output logic [7:0]              rd_data,
  // Core side
  input  wire logic               take,
  input  wire logic               load,
  input  wire logic [7:0]         load_data,
  output lcf_pkg::lcf_hbyte_s     in_byte
);

  // New byte wins over a same-cycle take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_holding_full <= 1'b0;
      in_byte            <= '0;
    end else if (wr) begin
      input_holding_full <= 1'b1;
      in_byte            <= wr_byte;
    end else if (take) begin
      input_holding_full <= 1'b0;
    end
  end

  // [RL18] response byte held until host reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_holding_full <= 1'b0;
      rd_data             <= 8'h00;
    end else if (load) begin
      output_holding_full <= 1'b1;
      rd_data             <= load_data;
    end else if (rd) begin
      output_holding_full <= 1'b0;
    end
  end

  property p_obf_set;
    @(posedge clk) disable iff (rst)
    load |=> output_holding_full && rd_data == $past(load_data);
  endproperty
  a_obf_set: assert property (p_obf_set) else $error("reply not held"); // RL18

endmodule

// >>> rtl/lcf_top.sv
// Four-channel moving-average filter, setpoint compare and host command port
//
// Contract
// [RL1] Each new sample of a channel overwrites that channel's oldest one.
// [RL2] After each sample the mean of retained samples is the new result.
// [RL3] Depth 1 passes the raw sample straight through.
// [RL4] Depth 2 averages current and previous sample.
// [RL5] Depth 4 averages the four newest samples.
// [RL6] Depth 8 averages the eight newest samples.
// [RL7] Only depths 1, 2, 4, 8 are stored; any other value stores 1.
// [RL8] One stored depth per channel, returned on the host's request.
// [RL9] A write command commits the supplied depth for the named channel.
// [RL10] Compare-enable bits 0..3 map to channels 1..4 and outputs 1..4.
// [RL11] Enabled channel compares result with preset on every measurement; here only once the channel's history is full.
// [RL12] Result above preset energizes the tied output.
// [RL13] Result at or below preset de-energizes the tied output.
// [RL14] Disabled compare leaves the tied output unchanged.
// [RL15] Inactive channel: no measurement, no compare, output unchanged.
// [RL16] A read command returns the compare-enable field in the low bits.
// [RL17] Host waits for the input holding register to empty before writing.
// [RL18] Replies go to the output holding register; host waits, bounded.
// [RL19] After enable rises, output settles at the next valid measurement; here the first one with a full history.
// [RL20] After enable falls, output keeps the last comparison's value.
// [RL21] Energized pin is low, de-energized high; read-back 1 means low.
// [RL22] A depth change clears that channel's sample history.
`timescale 1ns/1ps
module lcf_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Measurements and setpoints
  input  wire logic                         sample_valid,
  input  wire lcf_pkg::lcf_sample_s         sample,
  input  wire logic [3:0]                   chan_active,
  input  wire logic [3:0][lcf_pkg::SAMPLE_W-1:0] preset,
  // Host byte port
  input  wire logic                         host_wr,
  input  wire lcf_pkg::lcf_hbyte_s          host_wr_byte,
  input  wire logic                         host_rd,
  output logic                              input_holding_full,
  output logic                              output_holding_full,
  output logic [7:0]                        host_rd_data,
  // Filtered results
  output logic [3:0]                        filtered_valid,
  output logic [3:0][lcf_pkg::SAMPLE_W-1:0] filtered_data,
  // Nonvolatile depth commit
  output logic                              nv_wr,
  output logic [1:0]                        nv_wr_chan,
  output logic [1:0]                        nv_wr_depth,
  // Setpoint outputs, active low
  output logic                              setpoint_out_1,
  output logic                              setpoint_out_2,
  output logic                              setpoint_out_3,
  output logic                              setpoint_out_4
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  lcf_pkg::lcf_state_e state;
  lcf_pkg::lcf_state_e next_state;
  lcf_pkg::lcf_hbyte_s in_byte;
  logic                take;
  logic                obuf_load;
  logic [7:0]          reply;
  logic [1:0]          sel_ch;
  logic [3:0][1:0]     depth;
  logic [3:0]          mode;
  logic [3:0]          pin_level;
  logic [3:0]          f_in_valid;
  logic [3:0]          f_clear;
  logic [3:0]          f_full;
  logic [1:0]          new_depth;
  logic                is_cmd_take;
  logic                is_data_take;

  // ---------------------------------------------------------------
  // Host holding registers
  // ---------------------------------------------------------------
  lcf_host_port u_port (
    .clk                 (clk),
    .rst                 (rst),
    .wr                  (host_wr),
    .wr_byte             (host_wr_byte),
    .rd                  (host_rd),
    .input_holding_full  (input_holding_full),
    .output_holding_full (output_holding_full),
    .rd_data             (host_rd_data),
    .take                (take),
    .load                (obuf_load),
    .load_data           (reply),
    .in_byte             (in_byte)
  );

  // Bytes wait while a reply is pending, which is what paces the host
  // [RL17] host must see input_holding_full low before writing
  assign take         = input_holding_full && state != lcf_pkg::ST_REPLY;
  assign is_cmd_take  = take && in_byte.is_cmd;
  assign is_data_take = take && !in_byte.is_cmd;
  assign obuf_load    = state == lcf_pkg::ST_REPLY && !output_holding_full;

  // [RL7] unsupported depth values fall back to depth 1
  always_comb begin
    case (in_byte.data)
      8'h01:   new_depth = lcf_pkg::DEPTH_1;
      8'h02:   new_depth = lcf_pkg::DEPTH_2;
      8'h04:   new_depth = lcf_pkg::DEPTH_4;
      8'h08:   new_depth = lcf_pkg::DEPTH_8;
      default: new_depth = lcf_pkg::DEPTH_1;
    endcase
  end

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  // A command byte always restarts the sequence, so a host that
  // gave up halfway after a timeout can resynchronise.
  always_comb begin
    next_state = state;
    if (is_cmd_take) begin
      case (in_byte.data)
        lcf_pkg::CMD_GET_FILTER: next_state = lcf_pkg::ST_FCH;
        lcf_pkg::CMD_SET_FILTER: next_state = lcf_pkg::ST_SCH;
        lcf_pkg::CMD_GET_MODE:   next_state = lcf_pkg::ST_REPLY;
        lcf_pkg::CMD_SET_MODE:   next_state = lcf_pkg::ST_SMODE;
        lcf_pkg::CMD_GET_IO:     next_state = lcf_pkg::ST_REPLY;
        default:                 next_state = lcf_pkg::ST_IDLE;
      endcase
    end else begin
      case (state)
        lcf_pkg::ST_IDLE:  next_state = lcf_pkg::ST_IDLE;
        lcf_pkg::ST_FCH: begin
          if (is_data_take) next_state = lcf_pkg::ST_REPLY;
        end
        lcf_pkg::ST_SCH: begin
          if (is_data_take) next_state = lcf_pkg::ST_SVAL;
        end
        lcf_pkg::ST_SVAL: begin
          if (is_data_take) next_state = lcf_pkg::ST_IDLE;
        end
        lcf_pkg::ST_SMODE: begin
          if (is_data_take) next_state = lcf_pkg::ST_IDLE;
        end
        lcf_pkg::ST_REPLY: begin
          if (obuf_load) next_state = lcf_pkg::ST_IDLE;
        end
        default:           next_state = lcf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= lcf_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Channel named by the host, 0-based
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_ch <= 2'h0;
    end else if (is_data_take && (state == lcf_pkg::ST_FCH ||
                                  state == lcf_pkg::ST_SCH)) begin
      sel_ch <= in_byte.data[1:0];
    end
  end

  // Reply byte latched when the request completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reply <= 8'h00;
    end else if (is_cmd_take &&
                 in_byte.data == lcf_pkg::CMD_GET_MODE) begin
      // [RL16] compare-enable field read-back
      reply <= {4'h0, mode};
    end else if (is_cmd_take &&
                 in_byte.data == lcf_pkg::CMD_GET_IO) begin
      // [RL21] read-back 1 for a low pin
      reply <= {4'h0, ~pin_level};
    end else if (is_data_take && state == lcf_pkg::ST_FCH) begin
      // [RL8] stored depth returned as 1, 2, 4 or 8
      reply <= 8'h01 << depth[in_byte.data[1:0]];
    end
  end

  // ---------------------------------------------------------------
  // Stored settings
  // ---------------------------------------------------------------
  // Depth is held in flops here; nv_wr tells the storage to commit.
  // [RL9] commit supplied depth for the named channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      depth       <= {4{lcf_pkg::DEPTH_RST}};
      nv_wr       <= 1'b0;
      nv_wr_chan  <= 2'h0;
      nv_wr_depth <= lcf_pkg::DEPTH_RST;
    end else begin
      nv_wr <= 1'b0;
      if (is_data_take && state == lcf_pkg::ST_SVAL) begin
        depth[sel_ch] <= new_depth;
        nv_wr         <= 1'b1;
        nv_wr_chan    <= sel_ch;
        nv_wr_depth   <= new_depth;
      end
    end
  end

  // [RL22] history cleared only when the depth really changes
  always_comb begin
    f_clear = 4'h0;
    if (is_data_take && state == lcf_pkg::ST_SVAL &&
        new_depth != depth[sel_ch]) begin
      f_clear[sel_ch] = 1'b1;
    end
  end

  // [RL10] bit n steers channel n+1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= lcf_pkg::MODE_RST;
    end else if (is_data_take && state == lcf_pkg::ST_SMODE) begin
      mode <= in_byte.data[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Per-channel filters
  // ---------------------------------------------------------------
  // [RL5] each channel averages 1, 2, 4 or 8 newest samples
  for (genvar ch = 0; ch < lcf_pkg::NUM_CH; ch++) begin : g_ch
    // [RL15] inactive channel takes no measurement
    assign f_in_valid[ch] = sample_valid && sample.chan == 2'(ch) &&
                            chan_active[ch];

    lcf_avg u_avg (
      .clk       (clk),
      .rst       (rst),
      .clear     (f_clear[ch]),
      .depth     (depth[ch]),
      .in_valid  (f_in_valid[ch]),
      .in_data   (sample.data),
      .out_valid (filtered_valid[ch]),
      .out_data  (filtered_data[ch]),
      .full      (f_full[ch])
    );

    // ---------------------------------------------------------------
    // Setpoint compare
    // ---------------------------------------------------------------
    // Compare waits for a filled history so a fresh enable never
    // acts on a mean diluted by cleared slots.
    // [RL11] [RL19] compare on each valid measurement once filled
    // [RL14] [RL20] pin holds while compare is off
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pin_level[ch] <= lcf_pkg::PIN_RST[ch];
      end else if (filtered_valid[ch] && chan_active[ch] &&
                   mode[ch] && f_full[ch]) begin
        // [RL12] [RL13] above preset drives the pin low
        pin_level[ch] <= !(filtered_data[ch] > preset[ch]);
      end
    end
  end

  // [RL21] energized is a low pin
  assign setpoint_out_1 = pin_level[0];
  assign setpoint_out_2 = pin_level[1];
  assign setpoint_out_3 = pin_level[2];
  assign setpoint_out_4 = pin_level[3];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_inactive;
    @(posedge clk) disable iff (rst)
    sample_valid && sample.chan == 2'h0 && !chan_active[0]
      |=> !filtered_valid[0] ##1 $stable(pin_level[0]);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive measured"); // RL15

  property p_energize;
    @(posedge clk) disable iff (rst)
    filtered_valid[1] && chan_active[1] && mode[1] && f_full[1] &&
    filtered_data[1] > preset[1] |=> !setpoint_out_2;
  endproperty
  a_energize: assert property (p_energize) else $error("not energized"); // RL12

  property p_deenergize;
    @(posedge clk) disable iff (rst)
    filtered_valid[1] && chan_active[1] && mode[1] && f_full[1] &&
    filtered_data[1] <= preset[1] |=> setpoint_out_2;
  endproperty
  a_deenergize: assert property (p_deenergize) else $error("energized"); // RL13

  property p_hold;
    @(posedge clk) disable iff (rst)
    !mode[2] |=> pin_level[2] == $past(pin_level[2]);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved w/o enable"); // RL14

  property p_get_mode;
    @(posedge clk) disable iff (rst)
    is_cmd_take && in_byte.data == lcf_pkg::CMD_GET_MODE &&
    !output_holding_full |=> obuf_load && reply == {4'h0, mode};
  endproperty
  a_get_mode: assert property (p_get_mode) else $error("mode reply bad"); // RL16

  property p_sanitize;
    @(posedge clk) disable iff (rst)
    is_data_take && state == lcf_pkg::ST_SVAL &&
    !(in_byte.data inside {8'h01, 8'h02, 8'h04, 8'h08})
      |=> depth[$past(sel_ch)] == lcf_pkg::DEPTH_1 && nv_wr;
  endproperty
  a_sanitize: assert property (p_sanitize) else $error("bad depth kept"); // RL7

  property p_commit;
    @(posedge clk) disable iff (rst)
    nv_wr |-> depth[nv_wr_chan] == nv_wr_depth;
  endproperty
  a_commit: assert property (p_commit) else $error("commit mismatch"); // RL9

  property p_reply_bound;
    @(posedge clk) disable iff (rst)
    state == lcf_pkg::ST_REPLY && !output_holding_full
      |=> output_holding_full && state == lcf_pkg::ST_IDLE;
  endproperty
  a_reply_bound: assert property (p_reply_bound) else $error("no reply"); // RL18

  c_set_filter: cover property (@(posedge clk) nv_wr);
  c_energize:   cover property (@(posedge clk) !setpoint_out_1);
  c_get_filter: cover property (@(posedge clk)
    state == lcf_pkg::ST_FCH ##1 state == lcf_pkg::ST_REPLY);
  c_mode_rise:  cover property (@(posedge clk) $rose(mode[0]));

endmodule

// >>> testbench/lcf_host_model.sv
// Host software model for the byte command handshake
`timescale 1ns/1ps
module lcf_host_model (
  // Clock
  input  wire logic           clk,
  // Byte port
  input  wire logic           in_full,
  input  wire logic           out_full,
  input  wire logic [7:0]     rdata,
  output logic                wr,
  output lcf_pkg::lcf_hbyte_s wbyte,
  output logic                rd,
  output int                  tmo
);
  initial begin
    wr    = 1'b0;
    rd    = 1'b0;
    wbyte = '0;
    tmo   = 0;
  end

  task automatic put(input logic c, input logic [7:0] b);
    int n;
    n = 0;
    while (in_full !== 1'b0 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 64) tmo++;
    @(posedge clk);
    wr    <= 1'b1;
    wbyte <= {c, b};
    @(posedge clk);
    wr    <= 1'b0;
    // Released bus shows junk, not the last byte
    wbyte <= ~{c, b};
    #1;
  endtask

  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    while (out_full !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 64) tmo++;
    b = rdata;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the filter and setpoint block
`timescale 1ns/1ps
module tb;
  logic                clk, rst, sv, ihf, ohf, nv_wr, hwr, hrd;
  lcf_pkg::lcf_sample_s smp;
  lcf_pkg::lcf_hbyte_s hb;
  logic [3:0]          act, fv, pins, ep, mode;
  logic [3:0][23:0]    pre, fd;
  logic [7:0]          hrdata, r;
  logic [1:0]          nvc, nvd;
  logic [3:0]          nvq;
  logic [23:0]         h [4][8];
  int                  fill [4], nd [4];
  int                  fail_count, n_tests, tmo;

  lcf_top lcf_top_inst (.clk(clk), .rst(rst), .sample_valid(sv),
    .sample(smp), .chan_active(act), .preset(pre), .host_wr(hwr),
    .host_wr_byte(hb), .host_rd(hrd), .input_holding_full(ihf),
    .output_holding_full(ohf), .host_rd_data(hrdata),
    .filtered_valid(fv), .filtered_data(fd), .nv_wr(nv_wr),
    .nv_wr_chan(nvc), .nv_wr_depth(nvd), .setpoint_out_1(pins[0]),
    .setpoint_out_2(pins[1]), .setpoint_out_3(pins[2]),
    .setpoint_out_4(pins[3]));
  lcf_host_model host_inst (.clk(clk), .in_full(ihf), .out_full(ohf),
    .rdata(hrdata), .wr(hwr), .wbyte(hb), .rd(hrd), .tmo(tmo));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (nv_wr === 1'b1) nvq <= {nvc, nvd};
  end

  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %0h not %0h", $time, m, seen, exp);
    end
  endtask

  task automatic summarize();
    fail_count += tmo;
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic query(input logic [7:0] c, input int ch);
    host_inst.put(1'b1, c);
    if (ch >= 0) host_inst.put(1'b0, 8'(ch));
    host_inst.get(r);
  endtask

  task automatic set_depth(input int ch, input int v);
    int e;
    e = (v == 1 || v == 2 || v == 4 || v == 8) ? v : 1;
    host_inst.put(1'b1, lcf_pkg::CMD_SET_FILTER);
    host_inst.put(1'b0, 8'(ch));
    host_inst.put(1'b0, 8'(v));
    // Depth change wipes the history
    if (e != nd[ch]) begin
      fill[ch] = 0;
      for (int i = 0; i < 8; i++) h[ch][i] = '0;
    end
    nd[ch] = e;
    query(lcf_pkg::CMD_GET_FILTER, ch);
    chk(r, e, "depth");
    chk(nvq, {2'(ch), 2'($clog2(e))}, "commit");
  endtask

  task automatic set_mode(input logic [3:0] m);
    host_inst.put(1'b1, lcf_pkg::CMD_SET_MODE);
    host_inst.put(1'b0, {4'hA, m});
    mode = m;
    query(lcf_pkg::CMD_GET_MODE, -1);
    chk(r, {4'h0, m}, "mode");
  endtask

  task automatic feed(input int ch, input logic [23:0] d);
    logic [26:0] s;
    s = '0;
    @(posedge clk);
    sv  <= 1'b1;
    smp <= {2'(ch), d};
    @(posedge clk);
    sv  <= 1'b0;
    smp <= ~{2'(ch), d};
    #1;
    if (!act[ch]) begin
      chk(fv, 4'h0, "inactive");
    end else begin
      for (int i = 7; i > 0; i--) h[ch][i] = h[ch][i-1];
      h[ch][0] = d;
      if (fill[ch] < 8) fill[ch]++;
      for (int i = 0; i < nd[ch]; i++) s += h[ch][i];
      s = s / nd[ch];
      chk(fv, 4'h1 << ch, "valid");
      chk(fd[ch], s, "mean");
      if (mode[ch] && fill[ch] >= nd[ch]) ep[ch] = !(s > pre[ch]);
    end
    @(posedge clk);
    #1;
    chk(pins, ep, "pins");
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    int dv[6] = '{3, 2, 4, 8, 5, 1};
    int dl[4] = '{8, 4, 2, 1};
    rst = 1'b1;
    sv = 1'b0;
    smp = '0;
    act = 4'hF;
    ep = 4'hF;
    mode = 4'h0;
    nvq = 4'h0;
    fail_count = 0;
    n_tests = 0;
    pre = {24'h83, 24'h82, 24'h81, 24'h80};
    foreach (nd[i]) nd[i] = 1;
    foreach (fill[i]) fill[i] = 0;
    foreach (h[i, j]) h[i][j] = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(pins, 4'hF, "reset pins");
    query(lcf_pkg::CMD_GET_FILTER, 0);
    chk(r, 1, "reset depth");
    foreach (dv[i]) set_depth(2, dv[i]);
    set_mode(4'h1);
    foreach (dl[i]) begin
      set_depth(0, dl[i]);
      for (int k = 1; k <= 9; k++) feed(0, 24'(k * 'h23));
    end
    feed(0, 24'h80);
    feed(0, 24'h81);
    set_mode(4'h0);
    feed(0, 24'h00);
    query(lcf_pkg::CMD_GET_IO, -1);
    chk(r, {4'h0, ~ep}, "io readback");
    set_mode(4'h1);
    @(posedge clk);
    act <= 4'hE;
    feed(0, 24'h00);
    @(posedge clk);
    act <= 4'hF;
    set_mode(4'hE);
    for (int c = 1; c < 4; c++) feed(c, 24'h82);
    feed(1, 24'h81);
    query(lcf_pkg::CMD_GET_IO, -1);
    chk(r, {4'h0, ~ep}, "io map");
    summarize();
  end
endmodule
